// file: include/sadc_consts.svh
// Offsets, field positions, reset values and cycle counts of the converter control block.
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
`define SADC_OFF_CTRL 10'h000
`define SADC_OFF_STAT 10'h001
`define SADC_IDX_RES_FIRST 10'h002
`define SADC_IDX_RES_LAST 10'h009
`define SADC_CTRL_RESET 32'h00000000
`define SADC_CTRL_MASK 32'h00ff7fff
`define SADC_F_MODE_HI 2
`define SADC_F_MODE_LO 0
`define SADC_F_CHAN_HI 5
`define SADC_F_CHAN_LO 3
`define SADC_F_START 6
`define SADC_F_EXT 7
`define SADC_F_RES10 8
`define SADC_F_SH 9
`define SADC_F_CLK_HI 11
`define SADC_F_CLK_LO 10
`define SADC_F_EXP_HI 13
`define SADC_F_EXP_LO 12
`define SADC_F_VREF 14
`define SADC_F_WGT_HI 23
`define SADC_F_WGT_LO 16
`define SADC_S_BUSY 0
`define SADC_S_IRQ 1
`define SADC_S_CH_HI 6
`define SADC_S_CH_LO 4
`define SADC_CYC_SH10 6'd33
`define SADC_CYC_SH8 6'd28
`define SADC_CYC_NS10 6'd59
`define SADC_CYC_NS8 6'd49
`define SADC_CYC_SAMPLE 6'd3
`define SADC_BITS10 6'd10
`define SADC_BITS8 6'd8
`define SADC_SAR_MSB 10'h200
`define SADC_SEL_EXP_FIRST 4'h8
`define SADC_SEL_EXP_SECOND 4'h9
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2
`endif

// file: include/sadc_pkg.sv
// Types of the converter control block.
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_IDLE = 3'h1,
    SADC_ARMED = 3'h2,
    SADC_CONV = 3'h4
  } sadc_state_t;
  typedef enum logic [2:0] {
    SADC_ONESHOT = 3'h0,
    SADC_REPEAT = 3'h1,
    SADC_SWEEP_ONCE = 3'h2,
    SADC_SWEEP_REP0 = 3'h3,
    SADC_SWEEP_REP1 = 3'h4
  } sadc_mode_t;
  typedef enum logic [1:0] {
    SADC_EXP_NONE = 2'h0,
    SADC_EXP_FIRST = 2'h1,
    SADC_EXP_SECOND = 2'h2,
    SADC_EXP_OPAMP = 2'h3
  } sadc_exp_t;
endpackage : sadc_pkg

// file: include/sadc_mem_if.sv
// Result memory port between the sequencer and the result store.
`timescale 1ns/10ps
`default_nettype none
interface sadc_mem_if;
  logic wr_en;
  logic [2:0] wr_addr;
  logic [9:0] wr_data;
  logic rd_en;
  logic [2:0] rd_addr;
  logic [9:0] rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface : sadc_mem_if
`default_nettype wire

// file: rtl/sadc_clkdiv.sv
// Operation clock tick generator with divide-by-1, 2 and 4.
`timescale 1ns/10ps
`default_nettype none
module sadc_clkdiv (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control.
  input wire logic [1:0] i_sel,
  input wire logic i_restart,
  // Tick.
  output logic o_tick
);
  logic [1:0] cnt_ff;
  logic nxt_tick;

  always_comb begin
    if (i_restart) begin
      nxt_tick = 1'b0;
    end else if (i_sel[1]) begin
      nxt_tick = 1'b1;
    end else if (i_sel[0]) begin
      nxt_tick = cnt_ff[0];
    end else begin
      nxt_tick = (cnt_ff == 2'h3);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 2'h0;
    end else if (i_restart) begin
      cnt_ff <= 2'h0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= nxt_tick;
    end
  end

  property p_div4;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_sel == 2'h0 && $past(i_sel) == 2'h0 && o_tick) |=> (!o_tick || i_sel != 2'h0) [*3];
  endproperty
  a_div4: assert property (p_div4) else $error("Divide-by-four tick came early.");
  property p_div2;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_sel == 2'h1 && $past(i_sel) == 2'h1 && o_tick) |=> (!o_tick || i_sel != 2'h1);
  endproperty
  a_div2: assert property (p_div2) else $error("Divide-by-two tick came early.");
endmodule : sadc_clkdiv
`default_nettype wire

// file: rtl/sadc_mem.sv
// Eight-word store of conversion results with registered read data.
`timescale 1ns/10ps
`default_nettype none
module sadc_mem (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Memory port.
  sadc_mem_if.mem mp
);
  logic [9:0] mem_ff [0:7];

  always_ff @(posedge i_clk) begin
    if (mp.wr_en) begin
      mem_ff[mp.wr_addr] <= mp.wr_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mp.rd_data <= 10'h000;
    end else if (mp.rd_en) begin
      mp.rd_data <= mem_ff[mp.rd_addr];
    end
  end
endmodule : sadc_mem
`default_nettype wire

// file: rtl/sadc_top.sv
// Successive-approximation converter sequencer with its AXI4-Lite register slave.
`timescale 1ns/10ps
`default_nettype none
`include "sadc_consts.svh"
module sadc_top (
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  // AXI4-Lite write channels.
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read channels.
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [11:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Trigger pin and analog front end.
  input wire logic I_EXT_TRIGGER_PIN,
  input wire logic I_CMP_HIGH,
  output logic [3:0] O_INPUT_SEL,
  output logic [9:0] O_DAC_CODE,
  output logic O_SAMPLE,
  output logic O_OPAMP_ROUTE,
  output logic O_VREF_CONNECT,
  output logic O_BUSY
);
  logic [31:0] ctrl_ff;
  logic irq_ff;
  sadc_pkg::sadc_state_t state_ff, nxt_state;
  sadc_pkg::sadc_mode_t mode;
  sadc_pkg::sadc_exp_t exp_sel;
  logic [5:0] cyc_ff, total, bstart, tcnt_ff;
  logic [9:0] sar_ff, mask_ff, dec;
  logic [2:0] cur_ch_ff, last_ch, first_ch, next_ch;
  logic wdup_ff, res10, sh_en, ext, start, tick, done, run_end, go_conv, trig_fall;
  logic [2:0] trig_sync_ff, cmp_sync_ff;
  logic trig_ff, cmp_ff, cmp_now, awr_ff, arr_ff, rpend_ff, wr_ctrl, wr_stat;
  logic [9:0] waddr, raddr_ff;
  sadc_mem_if mif ();

  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  ////////////////////////////////////////////////////////////////////////////
  // Field decode and conversion length.
  assign mode = sadc_pkg::sadc_mode_t'(ctrl_ff[`SADC_F_MODE_HI:`SADC_F_MODE_LO]);
  assign exp_sel = sadc_pkg::sadc_exp_t'(ctrl_ff[`SADC_F_EXP_HI:`SADC_F_EXP_LO]);
  assign last_ch = ctrl_ff[`SADC_F_CHAN_HI:`SADC_F_CHAN_LO];
  assign res10 = ctrl_ff[`SADC_F_RES10];
  assign sh_en = ctrl_ff[`SADC_F_SH];
  assign ext = ctrl_ff[`SADC_F_EXT];
  assign start = ctrl_ff[`SADC_F_START];
  assign first_ch = (mode == sadc_pkg::SADC_ONESHOT || mode == sadc_pkg::SADC_REPEAT) ? last_ch : 3'h0;
  assign next_ch = (cur_ch_ff == last_ch) ? 3'h0 : cur_ch_ff + 3'h1;

  always_comb begin
    case ({res10, sh_en})
      2'b11: total = `SADC_CYC_SH10;
      2'b01: total = `SADC_CYC_SH8;
      2'b10: total = `SADC_CYC_NS10;
      default: total = `SADC_CYC_NS8;
    endcase
  end
  assign bstart = total - (res10 ? `SADC_BITS10 : `SADC_BITS8) - 6'd1;

  assign trig_fall = trig_ff && (trig_sync_ff[1] == trig_sync_ff[2]) && !trig_sync_ff[2];
  assign done = (state_ff == sadc_pkg::SADC_CONV) && tick && (cyc_ff == total - 6'd1);
  assign run_end = done && (mode == sadc_pkg::SADC_ONESHOT
                   || (mode == sadc_pkg::SADC_SWEEP_ONCE && cur_ch_ff == last_ch));
  assign go_conv = (nxt_state == sadc_pkg::SADC_CONV && state_ff != sadc_pkg::SADC_CONV)
                   || (state_ff == sadc_pkg::SADC_CONV && start && ext && trig_fall);
  // comparator counts once the last two stages agree.
  assign cmp_now = (cmp_sync_ff[1] == cmp_sync_ff[2]) ? cmp_sync_ff[2] : cmp_ff;
  assign dec = cmp_now ? sar_ff : (sar_ff & ~mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sadc_pkg::SADC_IDLE: begin
        if (start) begin
          nxt_state = ext ? sadc_pkg::SADC_ARMED : sadc_pkg::SADC_CONV;
        end
      end
      sadc_pkg::SADC_ARMED: begin
        if (!start) begin
          nxt_state = sadc_pkg::SADC_IDLE;
        end else if (trig_fall || !ext) begin
          nxt_state = sadc_pkg::SADC_CONV;
        end
      end
      sadc_pkg::SADC_CONV: begin
        if (!start) begin
          nxt_state = sadc_pkg::SADC_IDLE;
        end else if (run_end) begin
          nxt_state = ext ? sadc_pkg::SADC_ARMED : sadc_pkg::SADC_IDLE;
        end
      end
      default: nxt_state = sadc_pkg::SADC_IDLE;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_ff <= sadc_pkg::SADC_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation and channel stepping.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cyc_ff <= 6'h00;
      sar_ff <= 10'h000;
      mask_ff <= 10'h000;
      O_DAC_CODE <= 10'h000;
      cur_ch_ff <= 3'h0;
      wdup_ff <= 1'b0;
    end else if (go_conv) begin
      cyc_ff <= 6'h00;
      sar_ff <= 10'h000;
      mask_ff <= 10'h000;
      O_DAC_CODE <= 10'h000;
      cur_ch_ff <= first_ch;
      wdup_ff <= 1'b0;
    end else if (state_ff == sadc_pkg::SADC_CONV && tick) begin
      if (done) begin
        cyc_ff <= 6'h00;
        sar_ff <= 10'h000;
        mask_ff <= 10'h000;
        O_DAC_CODE <= 10'h000;
        case (mode)
          sadc_pkg::SADC_SWEEP_ONCE, sadc_pkg::SADC_SWEEP_REP0: cur_ch_ff <= next_ch;
          sadc_pkg::SADC_SWEEP_REP1: begin
            if (ctrl_ff[`SADC_F_WGT_LO + 32'(cur_ch_ff)] && !wdup_ff) begin
              wdup_ff <= 1'b1;
            end else begin
              wdup_ff <= 1'b0;
              cur_ch_ff <= next_ch;
            end
          end
          default: cur_ch_ff <= cur_ch_ff;
        endcase
      end else begin
        cyc_ff <= cyc_ff + 6'd1;
        if (cyc_ff == bstart) begin
          sar_ff <= `SADC_SAR_MSB;
          mask_ff <= `SADC_SAR_MSB;
          O_DAC_CODE <= `SADC_SAR_MSB;
        end else if (cyc_ff > bstart) begin
          sar_ff <= dec | (mask_ff >> 1);
          O_DAC_CODE <= dec | (mask_ff >> 1);
          mask_ff <= mask_ff >> 1;
        end
      end
    end
  end

  assign mif.wr_en = done;
  assign mif.wr_addr = cur_ch_ff;
  assign mif.wr_data = dec;
  assign mif.rd_en = arr_ff;
  assign mif.rd_addr = 3'(I_ARADDR[5:2] - 4'h2);

  sadc_mem u_mem (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .mp(mif.mem)
  );

  // operation clock from the main clock.
  sadc_clkdiv u_div (
    .i_clk(I_SYS_CLK),
    .i_rst_n(I_RST_N),
    .i_sel(ctrl_ff[`SADC_F_CLK_HI:`SADC_F_CLK_LO]),
    .i_restart(go_conv),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      trig_sync_ff <= 3'h7;
      cmp_sync_ff <= 3'h0;
      trig_ff <= 1'b1;
      cmp_ff <= 1'b0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[1:0], I_EXT_TRIGGER_PIN};
      cmp_sync_ff <= {cmp_sync_ff[1:0], I_CMP_HIGH};
      if (trig_sync_ff[1] == trig_sync_ff[2]) begin
        trig_ff <= trig_sync_ff[2];
      end
      if (cmp_sync_ff[1] == cmp_sync_ff[2]) begin
        cmp_ff <= cmp_sync_ff[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Front-end outputs.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_INPUT_SEL <= 4'h0;
      O_SAMPLE <= 1'b0;
      O_OPAMP_ROUTE <= 1'b0;
      O_VREF_CONNECT <= 1'b0;
      O_BUSY <= 1'b0;
    end else begin
      case (exp_sel)
        sadc_pkg::SADC_EXP_FIRST: O_INPUT_SEL <= `SADC_SEL_EXP_FIRST;
        sadc_pkg::SADC_EXP_SECOND: O_INPUT_SEL <= `SADC_SEL_EXP_SECOND;
        default: O_INPUT_SEL <= {1'b0, cur_ch_ff};
      endcase
      O_SAMPLE <= (state_ff == sadc_pkg::SADC_CONV) && sh_en && !go_conv && (cyc_ff < `SADC_CYC_SAMPLE);
      O_OPAMP_ROUTE <= (exp_sel == sadc_pkg::SADC_EXP_OPAMP);
      O_VREF_CONNECT <= ctrl_ff[`SADC_F_VREF];
      O_BUSY <= (nxt_state == sadc_pkg::SADC_CONV);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  assign waddr = I_AWADDR[11:2];
  assign wr_ctrl = awr_ff && (waddr == `SADC_OFF_CTRL);
  assign wr_stat = awr_ff && (waddr == `SADC_OFF_STAT);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl_ff <= `SADC_CTRL_RESET;
    end else if (wr_ctrl) begin
      // software sets the start flag; its set wins over a hardware clear.
      for (int b = 0; b < 4; b++) begin
        if (I_WSTRB[b]) begin
          ctrl_ff[8*b +: 8] <= I_WDATA[8*b +: 8] & 8'(`SADC_CTRL_MASK >> (8*b));
        end
      end
    end else if (run_end && !ext) begin
      ctrl_ff[`SADC_F_START] <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_ff <= 1'b0;
    end else if (run_end) begin
      irq_ff <= 1'b1;
    end else if (wr_stat && I_WSTRB[0] && I_WDATA[`SADC_S_IRQ]) begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      awr_ff <= 1'b0;
      O_BVALID <= 1'b0;
      O_BRESP <= `SADC_RESP_OKAY;
    end else begin
      awr_ff <= !awr_ff && !O_BVALID && I_AWVALID && I_WVALID;
      if (awr_ff) begin
        O_BVALID <= 1'b1;
        O_BRESP <= (wr_ctrl || wr_stat) ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
      end else if (I_BREADY) begin
        O_BVALID <= 1'b0;
      end
    end
  end
  assign O_AWREADY = awr_ff;
  assign O_WREADY = awr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register reads.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arr_ff <= 1'b0;
      rpend_ff <= 1'b0;
      raddr_ff <= 10'h000;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h00000000;
      O_RRESP <= `SADC_RESP_OKAY;
    end else begin
      arr_ff <= !arr_ff && !rpend_ff && !O_RVALID && I_ARVALID;
      rpend_ff <= arr_ff;
      if (arr_ff) begin
        raddr_ff <= I_ARADDR[11:2];
      end
      if (rpend_ff) begin
        O_RVALID <= 1'b1;
        O_RRESP <= `SADC_RESP_OKAY;
        if (raddr_ff == `SADC_OFF_CTRL) begin
          O_RDATA <= ctrl_ff;
        end else if (raddr_ff == `SADC_OFF_STAT) begin
          O_RDATA <= {25'h0000000, cur_ch_ff, 2'h0, irq_ff, O_BUSY};
        end else if (raddr_ff >= `SADC_IDX_RES_FIRST && raddr_ff <= `SADC_IDX_RES_LAST) begin
          O_RDATA <= {22'h000000, mif.rd_data};
        end else begin
          O_RDATA <= 32'h00000000;
          O_RRESP <= `SADC_RESP_SLVERR;
        end
      end else if (I_RREADY) begin
        O_RVALID <= 1'b0;
      end
    end
  end
  assign O_ARREADY = arr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tcnt_ff <= 6'h00;
    end else if (go_conv || done) begin
      tcnt_ff <= 6'h00;
    end else if (state_ff == sadc_pkg::SADC_CONV && tick) begin
      tcnt_ff <= tcnt_ff + 6'd1;
    end
  end

  sequence s_end_oneshot;
    done && mode == sadc_pkg::SADC_ONESHOT && !ext && !wr_ctrl;
  endsequence
  sequence s_halted;
    state_ff == sadc_pkg::SADC_IDLE && irq_ff && !start;
  endsequence
  property p_oneshot_end;
    s_end_oneshot |=> s_halted;
  endproperty
  a_oneshot_end: assert property (p_oneshot_end) else $error("One-shot end not halted.");
  property p_sh_len;
    (done && sh_en) |-> tcnt_ff == (res10 ? 6'd32 : 6'd27);
  endproperty
  a_sh_len: assert property (p_sh_len) else $error("Sample-and-hold length wrong.");
  property p_nosh_len;
    (done && !sh_en) |-> tcnt_ff == (res10 ? 6'd58 : 6'd48);
  endproperty
  a_nosh_len: assert property (p_nosh_len) else $error("Conversion length wrong.");
  property p_repeat;
    (done && mode == sadc_pkg::SADC_REPEAT && start && !wr_ctrl) |=> state_ff == sadc_pkg::SADC_CONV;
  endproperty
  a_repeat: assert property (p_repeat) else $error("Repeat mode stopped.");
  property p_sweep_step;
    (done && mode == sadc_pkg::SADC_SWEEP_ONCE && cur_ch_ff != last_ch && !go_conv && !wr_ctrl)
      |=> cur_ch_ff == $past(cur_ch_ff) + 3'h1;
  endproperty
  a_sweep_step: assert property (p_sweep_step) else $error("Sweep did not step.");
  property p_weight;
    (done && mode == sadc_pkg::SADC_SWEEP_REP1 && ctrl_ff[`SADC_F_WGT_LO + 32'(cur_ch_ff)] && !wdup_ff && !go_conv)
      |=> cur_ch_ff == $past(cur_ch_ff);
  endproperty
  a_weight: assert property (p_weight) else $error("Weighted input not repeated.");
  property p_low_bits;
    (done && !res10) |-> dec[1:0] == 2'h0;
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("8-bit result has low bits.");
  property p_ext_start;
    (state_ff == sadc_pkg::SADC_ARMED && start && trig_fall && !wr_ctrl) |=> O_BUSY ##1 tcnt_ff == 6'h00;
  endproperty
  a_ext_start: assert property (p_ext_start) else $error("Trigger edge did not start.");
  property p_abort;
    (state_ff == sadc_pkg::SADC_CONV && start && ext && trig_fall && !wr_ctrl) |=> cyc_ff == 6'h00 && !tick;
  endproperty
  a_abort: assert property (p_abort) else $error("Trigger edge did not restart.");
endmodule : sadc_top
`default_nettype wire

// file: sim/sadc_afe_model.sv
// Behavioural model of the analog inputs, comparator and trigger pin.
`timescale 1ns/10ps
`default_nettype none
module sadc_afe_model (
  // Clock.
  input wire logic i_clk,
  // Converter side.
  input wire logic [3:0] i_input_sel,
  input wire logic [9:0] i_dac_code,
  input wire logic i_fire,
  output logic o_cmp_high,
  output logic o_trigger_pin
);
  logic [3:0] low_cnt = 4'h0;
  function automatic logic [9:0] level(input logic [3:0] s);
    return {s, 6'h2d} ^ 10'h0ab;
  endfunction : level
  assign o_cmp_high = (level(i_input_sel) >= i_dac_code);
  always_ff @(posedge i_clk) begin
    if (i_fire) begin
      low_cnt <= 4'h8;
    end else if (low_cnt != 4'h0) begin
      low_cnt <= low_cnt - 4'h1;
    end
  end
  assign o_trigger_pin = (low_cnt == 4'h0);
endmodule : sadc_afe_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, fire = 1'h0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wr, bv, arr, rv, cmp, trg, smp, opa, vref, busy;
  logic [1:0] br, rr;
  logic [3:0] sel;
  logic [9:0] dac;
  int n_mismatch = 0, total_checks = 0, cyc = 0, busy_cnt = 0, samp_cnt = 0;
  logic [8:0] rows [9] = '{9'h01d, 9'h013, 9'h008, 9'h007, 9'h039, 9'h1fa, 9'h09c, 9'h116, 9'h046};
  sadc_top dut_u (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
    .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(4'hf), .O_BVALID(bv), .I_BREADY(bry),
    .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rry),
    .O_RDATA(rd), .O_RRESP(rr), .I_EXT_TRIGGER_PIN(trg), .I_CMP_HIGH(cmp), .O_INPUT_SEL(sel),
    .O_DAC_CODE(dac), .O_SAMPLE(smp), .O_OPAMP_ROUTE(opa), .O_VREF_CONNECT(vref), .O_BUSY(busy));
  sadc_afe_model afe_u (.i_clk(clk), .i_input_sel(sel), .i_dac_code(dac), .i_fire(fire),
    .o_cmp_high(cmp), .o_trigger_pin(trg));
  //////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    busy_cnt = busy_cnt + int'(busy === 1'h1);
    samp_cnt = samp_cnt + int'(smp === 1'h1);
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    bry <= 1'h1;
    do @(posedge clk); while (awr !== 1'h1);
    awv <= 1'h0;
    wv <= 1'h0;
    do @(posedge clk); while (bv !== 1'h1);
    bry <= 1'h0;
    chk(32'(br), 32'(er));
    @(posedge clk);
  endtask : axw
  task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
    ara <= a;
    arv <= 1'h1;
    rry <= 1'h1;
    do @(posedge clk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge clk); while (rv !== 1'h1);
    rry <= 1'h0;
    chk(rd & m, e);
    chk(32'(rr), 32'(er));
    @(posedge clk);
  endtask : rdchk
  task automatic idle;
    do @(posedge clk); while (busy !== 1'h0);
  endtask : idle
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [8:0] row;
    logic [31:0] ctl;
    logic [3:0] s;
    int dv, tot;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk(32'({busy, opa, vref, smp}), 32'h0);
    rdchk(12'h000, 32'hffffffff, 32'h0, 2'h0);
    for (int i = 0; i < 9; i++) begin
      row = rows[i];
      ctl = 32'h4000 | 32'({row[8:3], 2'h0, row[2:0], 3'h0});
      dv = row[6] ? 1 : (row[5] ? 2 : 4);
      tot = row[4] ? (row[3] ? 33 : 28) : (row[3] ? 59 : 49);
      s = (row[8:7] == 2'h1) ? 4'h8 : ((row[8:7] == 2'h2) ? 4'h9 : {1'h0, row[2:0]});
      axw(12'h000, ctl, 2'h0);
      repeat (100) @(posedge clk);
      chk(32'({opa, vref}), 32'({row[8:7] == 2'h3, 1'h1}));
      busy_cnt = 0;
      samp_cnt = 0;
      axw(12'h000, ctl | 32'h40, 2'h0);
      idle();
      chk(32'(busy_cnt >= tot * dv && busy_cnt <= tot * dv + dv + 3), 32'h1);
      chk(32'(row[4] ? (samp_cnt >= 3 * dv - 1 && samp_cnt <= 3 * dv + 1) : samp_cnt == 0), 32'h1);
      if (row[6:5] == 2'h0) rdchk(12'h008 + 12'({row[2:0], 2'h0}), 32'h3ff,
        32'(afe_u.level(s) & (row[3] ? 10'h3ff : 10'h3fc)), 2'h0);
      rdchk(12'h004, 32'h3, 32'h2, 2'h0);
      rdchk(12'h000, 32'h40, 32'h0, 2'h0);
      axw(12'h004, 32'h2, 2'h0);
      rdchk(12'h004, 32'h2, 32'h0, 2'h0);
    end
    rdchk(12'h100, 32'hffffffff, 32'h0, 2'h2);
    axw(12'h100, 32'h1, 2'h2);
    axw(12'h008, 32'h1, 2'h2);
    busy_cnt = 0;
    axw(12'h000, 32'h4352, 2'h0);
    idle();
    chk(32'(busy_cnt >= 396 && busy_cnt <= 420), 32'h1);
    for (int c = 0; c < 3; c++) rdchk(12'h008 + 12'(4 * c), 32'h3ff, 32'(afe_u.level(4'(c))), 2'h0);
    rdchk(12'h004, 32'h3, 32'h2, 2'h0);
    axw(12'h004, 32'h2, 2'h0);
    for (int m = 0; m < 3; m++) begin
      busy_cnt = 0;
      axw(12'h000, 32'h4350 | 32'(m == 0 ? 3'h1 : 3'(m + 2)) | (m == 2 ? 32'h20000 : 32'h0), 2'h0);
      repeat (2000) @(posedge clk);
      chk(32'(busy_cnt >= 1900), 32'h1);
      rdchk(12'h004, 32'h2, 32'h0, 2'h0);
      axw(12'h000, 32'h4000, 2'h0);
      idle();
      rdchk(12'h008 + 12'h008, 32'h3ff, 32'(afe_u.level(4'h2)), 2'h0);
    end
    axw(12'h000, 32'h43e8, 2'h0);
    repeat (20) @(posedge clk);
    chk(32'(busy), 32'h0);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    do @(posedge clk); while (busy !== 1'h1);
    repeat (60) @(posedge clk);
    fire <= 1'h1;
    busy_cnt = 0;
    @(posedge clk);
    fire <= 1'h0;
    idle();
    chk(32'(busy_cnt >= 132 && busy_cnt <= 145), 32'h1);
    rdchk(12'h01c, 32'h3ff, 32'(afe_u.level(4'h5)), 2'h0);
    rdchk(12'h004, 32'h2, 32'h2, 2'h0);
    axw(12'h000, 32'h4368, 2'h0);
    repeat (20) @(posedge clk);
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'({busy, vref}), 32'h0);
    rst_n <= 1'h1;
    @(posedge clk);
    rdchk(12'h000, 32'hffffffff, 32'h0, 2'h0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
